// [sdlc_bit_processor.sv]
// sdlc bit engine: nrzi, shifting, zero stuffing, pattern detect, fcs, diagnostic loop
//Contract
//R1 - header layout picked from header-omit and auto-select bits
//R2 - check-omit set drops fcs; closing flag follows data
//R3 - data moves only in whole octets
//R4 - nrzi compares present bit with previous bit both ways
//R5 - shifter serialises tx bytes and assembles rx bytes
//R6 - zeros inserted on transmit, removed on receive
//R7 - stuff zero after five ones; drop zero after five ones (transmit stuffs none when five ones end just before a closing flag)
//R8 - flag and go-ahead patterns detected and reported
//R9 - abort run of ones flags the frame as aborted
//R10 - 111110 detected as early go-ahead
//R11 - three-bit counter; eight zeros is shutoff
//R12 - any received one clears the shutoff counter
//R13 - fcs register preset to all ones before each calculation
//R14 - sixteen-bit fcs, polynomial x16+x12+x5+1
//R15 - fcs covers address, control, information; not flags
//R16 - fcs error raises no interrupt; cleared by next opening flag
//R17 - frame sequencing machine with cpu-visible registers
//R18 - software enters diagnostics by clearing diag enable bit
//R19 - diag data written feeds receiver; each write one clock pulse
//R20 - transmit output visible on diag enable bit per write
//R21 - test mode floats both diagnostic pins
`timescale 1ns/10ps
`default_nettype none
module sdlc_bit_processor (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_n,
	input  wire logic [4:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic [31:0]      o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_sclk,
	input  wire logic        i_rxd,
	output logic             o_txd,
	input  wire logic        i_diag_data_in,
	output logic             o_diag_data_out,
	output logic             o_diag_data_oe,
	input  wire logic        i_diag_enable_in,
	output logic             o_diag_enable_out,
	output logic             o_diag_enable_oe,
	output var sdlc_bit_pkg::rx_status_s o_rx_status
);
	import sdlc_bit_pkg::*;

	// link sampling: two flops before use
	logic [1:0] sclk_sync;
	logic [1:0] rxd_sync;
	logic       sclk_prev;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sclk_sync <= 2'h0;
			rxd_sync  <= 2'h3;
			sclk_prev <= 1'b0;
		end else begin
			sclk_sync <= {sclk_sync[0], i_sclk};
			rxd_sync  <= {rxd_sync[0], i_rxd};
			sclk_prev <= sclk_sync[1];
		end
	end

	// registers
	logic [5:0]  ctrl;
	logic [7:0]  tx_hold;
	logic        tx_hold_full;
	logic [7:0]  rx_hold;
	logic        diag_en_n;
	logic        diag_data;
	logic        diag_test;
	logic        diag_pulse;
	logic        rd_ack;
	logic        wr_ack;
	rx_status_s  rx_st;

	wire req       = i_avs_read | i_avs_write;
	wire [31:0] ba = {25'h0, i_avs_address, 2'h0};
	wire sel_ctrl  = ba == AV_ADDR_CTRL;
	wire sel_stat  = ba == AV_ADDR_STAT;
	wire sel_txd   = ba == AV_ADDR_TXD;
	wire sel_rxd   = ba == AV_ADDR_RXD;
	wire sel_diag  = ba == AV_ADDR_DIAG;
	wire wr_go     = i_avs_write & o_avs_waitrequest & ~wr_ack;
	wire rd_go     = i_avs_read & o_avs_waitrequest & ~rd_ack;
	wire diag_mode = ~diag_en_n; // R18

	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		if (sel_ctrl)      next_rdata = {26'h0, ctrl};
		else if (sel_stat) next_rdata = {22'h0, tx_hold_full, rx_st};
		else if (sel_txd)  next_rdata = {24'h0, tx_hold};
		else if (sel_rxd)  next_rdata = {24'h0, rx_hold};
		else if (sel_diag) next_rdata = {29'h0, diag_test, diag_en_n, diag_data};
	end

	// one wait cycle then ack; unmapped reads return zero, writes dropped
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0;
			rd_ack            <= 1'b0;
			wr_ack            <= 1'b0;
		end else begin
			rd_ack            <= rd_go;
			wr_ack            <= wr_go;
			o_avs_waitrequest <= ~((rd_go | wr_go) & req);
			if (rd_go)
				o_avs_readdata <= next_rdata;
		end
	end

	// link edges: real sclk outside diagnostics, port writes inside
	wire sclk_rise = diag_mode ? diag_pulse : (sclk_sync[1] & ~sclk_prev); // R19
	wire sclk_fall = diag_mode ? diag_pulse : (~sclk_sync[1] & sclk_prev); // R20
	wire line_in   = diag_mode ? diag_data : rxd_sync[1]; // R19

	// transmit path
	tx_state_e   tx_state;
	logic [7:0]  tx_shift;
	logic [2:0]  tx_bitcnt;
	logic [2:0]  tx_ones;
	logic [15:0] tx_fcs;
	logic        tx_fcs_hi;
	logic        tx_line;
	wire stuff_now = (tx_state == TX_DATA || tx_state == TX_FCS) && tx_ones == 3'(ONES_STUFF); // R7
	wire tx_bit    = stuff_now ? 1'b0 : tx_shift[0];
	wire byte_done = ~stuff_now && tx_bitcnt == 3'h7; // R3
	wire fcs_fb    = tx_fcs[0] ^ tx_bit;
	wire [15:0] tx_fcs_next = (tx_fcs >> 1) ^ (fcs_fb ? FCS_POLY_REFL : 16'h0); // R14
	wire next_tx_line = ctrl[CTRL_NRZI] ? (tx_bit ? tx_line : ~tx_line) : tx_bit; // R4

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_state  <= TX_IDLE;
			tx_shift  <= FLAG_BYTE;
			tx_bitcnt <= 3'h0;
			tx_ones   <= 3'h0;
			tx_fcs    <= FCS_PRESET;
			tx_fcs_hi <= 1'b0;
			tx_line   <= 1'b1;
			o_txd     <= 1'b1;
		end else if (sclk_fall) begin // R5
			tx_line <= next_tx_line;
			o_txd   <= next_tx_line;
			if (!stuff_now) tx_shift <= {1'b0, tx_shift[7:1]};
			tx_ones   <= (stuff_now || !tx_bit || tx_state == TX_FLAG) ? 3'h0 : tx_ones + 3'h1; // R6
			tx_bitcnt <= stuff_now ? tx_bitcnt : tx_bitcnt + 3'h1;
			if (tx_state == TX_DATA && !stuff_now) tx_fcs <= tx_fcs_next; // R15
			if (byte_done) begin
				case (tx_state)
					TX_IDLE: begin
						tx_shift <= FLAG_BYTE;
						if (ctrl[CTRL_TX_START]) tx_state <= TX_FLAG;
					end
					TX_FLAG: begin
						tx_fcs <= FCS_PRESET; // R13
						if (tx_hold_full) begin
							tx_shift <= tx_hold;
							tx_state <= TX_DATA;
						end else begin
							tx_shift <= FLAG_BYTE;
							if (!ctrl[CTRL_TX_START]) tx_state <= TX_IDLE;
						end
					end
					TX_DATA: begin
						if (tx_hold_full) tx_shift <= tx_hold;
						else if (ctrl[CTRL_CHECK_OMIT]) begin // R2
							tx_shift <= FLAG_BYTE;
							tx_state <= TX_FLAG;
						end else begin
							tx_shift  <= ~tx_fcs_next[7:0];
							tx_fcs_hi <= 1'b1;
							tx_state  <= TX_FCS;
						end
					end
					TX_FCS: begin
						tx_fcs_hi <= 1'b0;
						if (tx_fcs_hi) tx_shift <= ~tx_fcs[15:8];
						else begin
							tx_shift <= FLAG_BYTE;
							tx_state <= TX_FLAG;
						end
					end
					default: tx_state <= TX_IDLE;
				endcase
			end
			if (tx_state == TX_FCS && byte_done && tx_fcs_hi) tx_fcs <= tx_fcs_next;
		end
	end
	wire tx_take = sclk_fall && byte_done && tx_hold_full &&
		(tx_state == TX_DATA || tx_state == TX_FLAG);

	// receive path
	logic        rx_prev_line;
	logic [7:0]  rx_pat;
	logic [2:0]  rx_ones;
	logic [7:0]  rx_shift;
	logic [2:0]  rx_bitcnt;
	logic [2:0]  shut_cnt;
	logic        in_frame;
	logic [15:0] rx_fcs;
	logic [15:0] rx_fcs_byte;
	logic        rx_got_byte;
	logic [1:0]  rx_field;
	wire rx_bit   = ctrl[CTRL_NRZI] ? ~(line_in ^ rx_prev_line) : line_in; // R4
	wire [7:0] pat_n = {rx_bit, rx_pat[7:1]};
	wire is_flag  = pat_n == FLAG_BYTE; // R8
	wire is_ga    = pat_n[7:1] == 7'h7E && !is_flag; // R8
	wire is_abort = rx_ones == 3'(ONES_ABORT - 1) && rx_bit; // R9
	wire is_early = pat_n[7:2] == 6'h1F; // R10
	wire del_zero = rx_ones == 3'(ONES_STUFF) && !rx_bit; // R7
	wire rx_fb    = rx_fcs[0] ^ rx_bit;
	wire [15:0] rx_fcs_next = (rx_fcs >> 1) ^ (rx_fb ? FCS_POLY_REFL : 16'h0); // R14
	wire rx_data_bit = in_frame && !del_zero && !is_flag && !is_abort; // R6
	wire rx_byte_end = rx_data_bit && rx_bitcnt == 3'h7; // R3
	// header layout: 0 none left, 1 control left, 2 address+control
	wire [1:0] hdr_len = !ctrl[CTRL_HEADER_OMIT] ? 2'h2 : (ctrl[CTRL_AUTO_SELECT] ? 2'h1 : 2'h0); // R1

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_prev_line <= 1'b1;
			rx_pat       <= 8'h0;
			rx_ones      <= 3'h0;
			rx_shift     <= 8'h0;
			rx_bitcnt    <= 3'h0;
			shut_cnt     <= 3'h0;
			in_frame     <= 1'b0;
			rx_fcs       <= FCS_PRESET;
			rx_fcs_byte  <= FCS_PRESET;
			rx_got_byte  <= 1'b0;
			rx_field     <= 2'h0;
			rx_st        <= '0;
			rx_hold      <= 8'h0;
		end else begin
			// pattern reports are one-cycle pulses, one per link bit
			rx_st.rx_byte  <= 1'b0;
			rx_st.flag     <= 1'b0;
			rx_st.go_ahead <= 1'b0;
			rx_st.early_ga <= 1'b0;
			rx_st.shutoff  <= 1'b0;
			if (sclk_rise) begin
				rx_prev_line <= line_in;
				rx_pat       <= pat_n;
				rx_ones      <= rx_bit ? ((rx_ones == 3'h7) ? rx_ones : rx_ones + 3'h1) : 3'h0;
				shut_cnt     <= rx_bit ? 3'h0 : shut_cnt + 3'h1; // R12
				rx_st.shutoff  <= !rx_bit && shut_cnt == SHUT_MAX; // R11
				rx_st.go_ahead <= is_ga;
				rx_st.early_ga <= is_early;
				rx_st.flag     <= is_flag;
				if (is_abort && in_frame) begin
					rx_st.abort <= 1'b1; // R9
					in_frame    <= 1'b0;
					rx_got_byte <= 1'b0;
				end
				if (is_flag) begin
					// the flag's first seven bits already went through the shifter,
					// so the residue is taken from the last byte boundary
					if (rx_got_byte && rx_bitcnt == 3'h7 && !ctrl[CTRL_CHECK_OMIT])
						rx_st.fcs_err <= rx_fcs_byte != FCS_GOOD_RESID;
					else
						rx_st.fcs_err <= 1'b0; // R16
					rx_got_byte <= 1'b0;
					in_frame    <= 1'b1;
					rx_st.abort <= 1'b0;
					rx_fcs      <= FCS_PRESET; // R13
					rx_bitcnt   <= 3'h0;
					rx_field    <= 2'h0;
				end else if (rx_data_bit) begin
					rx_shift  <= {rx_bit, rx_shift[7:1]}; // R5
					rx_bitcnt <= rx_bitcnt + 3'h1;
					rx_fcs    <= rx_fcs_next; // R15
					if (rx_byte_end) begin
						rx_hold       <= {rx_bit, rx_shift[7:1]};
						rx_fcs_byte   <= rx_fcs_next;
						rx_got_byte   <= 1'b1;
						rx_st.rx_byte <= 1'b1; // R17
						if (rx_field != hdr_len) rx_field <= rx_field + 2'h1;
					end
				end
			end
			rx_st.field <= 2'(hdr_len - rx_field);
		end
	end

	// register writes; diag_pulse is one cycle per port write with the enable bit clear
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl         <= 6'h0;
			tx_hold      <= 8'h0;
			tx_hold_full <= 1'b0;
			diag_en_n    <= 1'b1;
			diag_data    <= 1'b1;
			diag_test    <= 1'b0;
			diag_pulse   <= 1'b0;
		end else begin
			diag_pulse <= wr_go && sel_diag && !i_avs_writedata[DIAG_ENABLE]; // R19
			if (wr_go && sel_ctrl) ctrl <= i_avs_writedata[5:0]; // R17
			if (wr_go && sel_diag) begin
				diag_data <= i_avs_writedata[DIAG_DATA];
				diag_en_n <= i_avs_writedata[DIAG_ENABLE]; // R18
				diag_test <= i_avs_writedata[DIAG_TEST];
			end
			if (wr_go && sel_txd && !tx_hold_full) begin
				tx_hold      <= i_avs_writedata[7:0];
				tx_hold_full <= 1'b1;
			end else if (tx_take)
				tx_hold_full <= 1'b0;
		end
	end

	// diagnostic pins: data pin quiet, enable pin echoes the line output
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_diag_data_out   <= 1'b0;
			o_diag_data_oe    <= 1'b0;
			o_diag_enable_out <= 1'b0;
			o_diag_enable_oe  <= 1'b0;
			o_rx_status       <= '0;
		end else begin
			o_diag_data_out   <= diag_data;
			o_diag_data_oe    <= 1'b0; // R21
			o_diag_enable_out <= tx_line; // R20
			o_diag_enable_oe  <= diag_mode && !diag_test; // R21
			o_rx_status       <= rx_st;
		end
	end
endmodule : sdlc_bit_processor
`default_nettype wire

// [sdlc_bit_pkg.sv]
// package: constants and carrier types for the sdlc bit engine
`default_nettype none
package sdlc_bit_pkg;
	localparam logic [7:0]  FLAG_BYTE      = 8'h7E;
	localparam logic [15:0] FCS_PRESET     = 16'hFFFF;
	localparam logic [15:0] FCS_POLY_REFL  = 16'h8408;
	localparam logic [15:0] FCS_GOOD_RESID = 16'hF0B8;
	localparam int          ONES_STUFF     = 5;
	localparam int          ONES_ABORT     = 7;
	localparam logic [2:0]  SHUT_MAX       = 3'h7;
	localparam logic [31:0] AV_ADDR_CTRL   = 32'h0000_0000;
	localparam logic [31:0] AV_ADDR_STAT   = 32'h0000_0004;
	localparam logic [31:0] AV_ADDR_TXD    = 32'h0000_0008;
	localparam logic [31:0] AV_ADDR_RXD    = 32'h0000_000C;
	localparam logic [31:0] AV_ADDR_DIAG   = 32'h0000_0010;
	localparam int          CTRL_CHECK_OMIT  = 0;
	localparam int          CTRL_HEADER_OMIT = 1;
	localparam int          CTRL_AUTO_SELECT = 2;
	localparam int          CTRL_NRZI        = 3;
	localparam int          CTRL_TX_START    = 4;
	localparam int          CTRL_TX_END      = 5;
	localparam int          DIAG_DATA        = 0;
	localparam int          DIAG_ENABLE      = 1;
	localparam int          DIAG_TEST        = 2;
	typedef struct packed {
		logic        flag;
		logic        go_ahead;
		logic        early_ga;
		logic        abort;
		logic        shutoff;
		logic        fcs_err;
		logic        rx_byte;
		logic [1:0]  field;
	} rx_status_s;
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_FLAG = 4'b0010,
		TX_DATA = 4'b0100,
		TX_FCS  = 4'b1000
	} tx_state_e;
endpackage : sdlc_bit_pkg
`default_nettype wire

// [sdlc_bit_processor_chk.sv]
// checker: port-level timing relations of the sdlc bit engine
`timescale 1ns/10ps
`default_nettype none
module sdlc_bit_processor_chk (
	input wire logic                    i_clk_sys,
	input wire logic                    i_rst_n,
	input wire logic                    i_avs_read,
	input wire logic                    i_avs_write,
	input wire logic [31:0]             o_avs_readdata,
	input wire logic                    o_avs_waitrequest,
	input wire logic                    o_diag_data_oe,
	input wire sdlc_bit_pkg::rx_status_s o_rx_status
);
	import sdlc_bit_pkg::*;
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	a_req_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("request not answered one cycle later");
	a_wait_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	a_rdata_hold: assert property ($changed(o_avs_readdata) |-> $past(i_avs_read && o_avs_waitrequest))
		else $error("read data changed without a read");
	a_data_float: assert property (!o_diag_data_oe)
		else $error("diagnostic data pin driven");
	a_flag_pulse: assert property (o_rx_status.flag |=> !o_rx_status.flag)
		else $error("flag report longer than one cycle");
	a_ga_pulse: assert property (o_rx_status.go_ahead |=> !o_rx_status.go_ahead)
		else $error("go-ahead report longer than one cycle");
	a_shut_pulse: assert property (o_rx_status.shutoff |=> !o_rx_status.shutoff)
		else $error("shutoff report longer than one cycle");
	a_fcs_clear: assert property ($fell(o_rx_status.fcs_err) |-> o_rx_status.flag || $past(o_rx_status.flag))
		else $error("check error cleared without a flag");
endmodule : sdlc_bit_processor_chk
`default_nettype wire

// [sdlc_remote_station.sv]
// partner: remote sdlc station making the link clock and line data
`timescale 1ns/10ps
`default_nettype none
module sdlc_remote_station (
	output logic      o_sclk,
	output logic      o_rxd,
	input  wire logic i_txd
);
	int   ones;
	logic txq[$];
	initial begin
		o_sclk = 1'b0;
		o_rxd  = 1'b1;
		ones   = 0;
	end
	// 400 ns per bit; odd offset keeps link edges off the system clock edges
	task automatic bit_out(input logic b);
		o_rxd = b;
		#113 o_sclk = 1'b1;
		txq.push_back(i_txd);
		#200 o_sclk = 1'b0;
		#87;
	endtask : bit_out
	task automatic send(input logic [7:0] v, input int n, input logic stuff);
		for (int i = 0; i < n; i++) begin
			bit_out(v[i]);
			ones = v[i] ? ones + 1 : 0;
			if (stuff && ones == 5) begin
				bit_out(1'b0);
				ones = 0;
			end
		end
	endtask : send
	// clock stands still; the inverted line must not pass for held data
	task automatic idle();
		o_rxd = ~o_rxd;
	endtask : idle
endmodule : sdlc_remote_station
`default_nettype wire

// [tb.sv]
// testbench: link frames, transmit stuffing, diagnostic loop and register bus
`timescale 1ns/10ps
`default_nettype none
module tb;
	import sdlc_bit_pkg::*;
	logic        clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed = 32'hF568;
	logic        avs_wait, sclk, rxd, txd, dd_out, dd_oe, de_out, de_oe, dd_pin, de_pin;
	rx_status_s  st, st_q;
	int          mismatches = 0, compares = 0, cyc = 0, nflag = 0, nga = 0, nsh = 0, n0, pos;
	logic [8:0]  w0, w1;
	always #25 clk_sys = ~clk_sys;
	// port pins carry pull-ups
	assign dd_pin = dd_oe ? dd_out : 1'b1;
	assign de_pin = de_oe ? de_out : 1'b1;
	sdlc_bit_processor dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_avs_address(avs_address),
		.i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
		.o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_wait), .i_sclk(sclk), .i_rxd(rxd),
		.o_txd(txd), .i_diag_data_in(dd_pin), .o_diag_data_out(dd_out), .o_diag_data_oe(dd_oe),
		.i_diag_enable_in(de_pin), .o_diag_enable_out(de_out), .o_diag_enable_oe(de_oe), .o_rx_status(st));
	sdlc_remote_station rem (.o_sclk(sclk), .o_rxd(rxd), .i_txd(txd));
	always @(posedge clk_sys) begin
		st_q <= st;
		nflag += (st.flag && !st_q.flag);
		nga += (st.go_ahead && !st_q.go_ahead);
		nsh += (st.shutoff && !st_q.shutoff);
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~w;
		avs_write <= w;
		do @(posedge clk_sys); while (avs_wait !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : av
	task automatic settle();
		rem.idle();
		repeat (6) @(posedge clk_sys);
	endtask : settle
	task automatic rx_frame(input logic [23:0] d, input logic bad);
		logic [15:0] c;
		c = FCS_PRESET;
		rem.send(FLAG_BYTE, 8, 1'b0);
		for (int i = 0; i < 24; i++) begin
			if (i % 8 == 0) rem.send(d[i +: 8], 8, 1'b1);
			c = (c[0] ^ d[i]) ? (c >> 1) ^ FCS_POLY_REFL : c >> 1;
		end
		c = ~c ^ {15'h0, bad};
		rem.send(c[7:0], 8, 1'b1);
		rem.send(c[15:8], 8, 1'b1);
		rem.send(FLAG_BYTE, 8, 1'b0);
		settle();
	endtask : rx_frame
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] r;
		r = s ^ (s << 13);
		r = r ^ (r >> 17);
		r = r ^ (r << 5);
		return r;
	endfunction : xorshift
	function automatic logic [8:0] txw(input int p);
		for (int k = 0; k < 9; k++) txw[k] = rem.txq[p + k];
	endfunction : txw
	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		seed = xorshift(seed);
		// ff byte forces a stuffed zero that must be dropped before the check
		rx_frame({seed[7:0], 8'hFF, 8'hC3}, 1'b0);
		chk(nflag, 2);
		chk(st.fcs_err, 0);
		rx_frame({8'h00, seed[15:8], 8'hFF}, 1'b1);
		chk(st.fcs_err, 1);
		rem.send(FLAG_BYTE, 8, 1'b0);
		settle();
		chk(st.fcs_err, 0);
		n0 = nga;
		rem.send(8'h7E, 7, 1'b0);
		settle();
		chk(nga, n0 + 1);
		rem.send(FLAG_BYTE, 8, 1'b0);
		rem.send(8'hFF, 7, 1'b0);
		settle();
		chk(st.abort, 1);
		$display("receive tests done");
		// no nrzi; data only, no check sequence, flags while idle
		av(1'b1, AV_ADDR_CTRL[6:2], 32'h13, rd);
		av(1'b1, AV_ADDR_TXD[6:2], 32'hFF, rd);
		rem.txq.delete();
		repeat (6) rem.send(FLAG_BYTE, 8, 1'b0);
		settle();
		pos = 0;
		for (int i = 0; i + 17 < rem.txq.size(); i++) begin
			w0 = txw(i);
			w1 = txw(i + 8);
			if (pos == 0 && w0[7:0] === FLAG_BYTE && w1[7:0] !== FLAG_BYTE) pos = i + 8;
		end
		chk(txw(pos), 9'h1DF);
		av(1'b1, AV_ADDR_CTRL[6:2], 32'h0, rd);
		$display("transmit test done");
		av(1'b1, AV_ADDR_DIAG[6:2], 32'h1, rd);
		n0 = nsh;
		for (int i = 0; i < 13; i++) av(1'b1, AV_ADDR_DIAG[6:2], {31'h0, i == 5}, rd);
		repeat (4) @(posedge clk_sys);
		chk(nsh, n0);
		repeat (8) av(1'b1, AV_ADDR_DIAG[6:2], 32'h0, rd);
		repeat (4) @(posedge clk_sys);
		chk(nsh, n0 + 1);
		chk(de_oe, 1);
		chk(de_out, txd);
		av(1'b1, AV_ADDR_DIAG[6:2], 32'h4, rd);
		chk(de_oe, 0);
		chk(dd_oe, 0);
		av(1'b1, AV_ADDR_DIAG[6:2], 32'h2, rd);
		$display("diagnostic test done");
		av(1'b0, 5'h1F, 32'h0, rd);
		chk(rd, 0);
		$display("register test done");
		final_report();
	end
endmodule : tb
bind sdlc_bit_processor sdlc_bit_processor_chk chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .o_diag_data_oe(o_diag_data_oe), .o_rx_status(o_rx_status));
`default_nettype wire
